// [include/supervisor_pkg.sv]
// Constants and types shared by the supply supervisor event-masking logic
package supervisor_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FAST_MASK_NS = 2000;
  localparam int NORMAL_MASK_NS = 150000;
  localparam int OSC_OVERSHOOT_NS = 6000;
  localparam int CLOCK_RISK_NS = 4000;
  localparam int CNT_W = 16;

  // Cycle counts derived from the times above (all divide exactly)
  localparam logic [CNT_W-1:0] FAST_MASK_CYCLES =
    CNT_W'(FAST_MASK_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] NORMAL_MASK_CYCLES =
    CNT_W'(NORMAL_MASK_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] OSC_OVERSHOOT_CYCLES =
    CNT_W'(OSC_OVERSHOOT_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] CLOCK_RISK_CYCLES =
    CNT_W'(CLOCK_RISK_NS * CLK_MHZ / 1000);

  // ---------------------------------------------------------------
  // Supervisor indices and main clock limits per core level (kHz)
  // ---------------------------------------------------------------
  localparam int HIGH_SIDE = 0;
  localparam int LOW_SIDE = 1;
  localparam logic [15:0] LIMIT_KHZ_LEVEL0 = 16'h0FA0;
  localparam logic [15:0] LIMIT_KHZ_LEVEL1 = 16'h1B58;
  localparam logic [15:0] LIMIT_KHZ_LEVEL2 = 16'h2AF8;
  localparam logic [15:0] LIMIT_KHZ_LEVEL3 = 16'h36B0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SLEEP0,
    PM_SLEEP1,
    PM_SLEEP2,
    PM_SLEEP3,
    PM_SLEEP4
  } power_mode_type;

  typedef struct packed {
    logic supervisor_enable;
    logic supervisor_fast_mode;
    logic supervisor_sleep_keep;
    logic supervisor_reset_enable;
  } supervisor_ctrl_type;

  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_MASK,
    WAKE_RISK
  } wake_state_type;

  // Value of each supervisor control after reset or soft clear
  localparam supervisor_ctrl_type CTRL_RESET = '{
    supervisor_enable: 1'b1,
    supervisor_fast_mode: 1'b0,
    supervisor_sleep_keep: 1'b0,
    supervisor_reset_enable: 1'b1
  };

endpackage : supervisor_pkg

// [rtl/supply_supervisor_event_masking.sv]
// Supply supervisor event masking, flags, resets and wake-up masking
//
// Notes on behaviour
// - Fast-mode comparator re-enabled: ignore its output for 2 us first.
// - Low side in normal mode: hold CPU 150 us after deepest wakes.
// - Accepted event sets its flag; with reset enable it requests a reset.
// - Flags set and comparator still settling: all pins go high-impedance.
// - Sleep keep at 0: comparator off in sleep 2-4, back on after.
// - After any reset both supervisors enable without starting the mask.
// - Disabled before soft clear: flags stay dead until control write.
// - Low side both off or both fast: wake mask lasts 2 us only.
// - Oscillator overshoots 6 us after wake; main clock risky for 4 us.
// - Overspeed hazard only above 4, 7, 11 or 14 MHz per core level.
`timescale 1ns/10ps

module supply_supervisor_event_masking #(
  parameter logic [supervisor_pkg::CNT_W-1:0] NORMAL_MASK_CYCLES =
    supervisor_pkg::NORMAL_MASK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_power_up_clear,
  input wire supervisor_pkg::power_mode_type power_mode,
  input wire logic [1:0] supervisor_ctrl_write,
  input wire supervisor_pkg::supervisor_ctrl_type supervisor_ctrl_wdata,
  input wire logic [1:0] supervisor_trip,
  input wire logic [1:0] supervisor_event_clear,
  input wire logic low_monitor_enable,
  input wire logic low_monitor_fast,
  input wire logic [1:0] core_level,
  input wire logic [15:0] main_clock_khz,
  input wire logic [2:0] main_clock_divider,
  output supervisor_pkg::supervisor_ctrl_type [1:0] supervisor_ctrl,
  output logic [1:0] supervisor_event_flag,
  output logic [1:0] flag_function_active,
  output logic [1:0] comparator_on,
  output logic power_on_reset_request,
  output logic pins_tristate,
  output logic cpu_hold,
  output logic clock_overspeed_risk
);

  localparam int W = supervisor_pkg::CNT_W;
  localparam logic [W-1:0] ONE = W'(1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Main clock limit for a core level, in kHz
  function automatic logic [15:0] clock_limit_khz(input logic [1:0] level);
    case (level)
      2'h0: clock_limit_khz = supervisor_pkg::LIMIT_KHZ_LEVEL0;
      2'h1: clock_limit_khz = supervisor_pkg::LIMIT_KHZ_LEVEL1;
      2'h2: clock_limit_khz = supervisor_pkg::LIMIT_KHZ_LEVEL2;
      default: clock_limit_khz = supervisor_pkg::LIMIT_KHZ_LEVEL3;
    endcase
  endfunction : clock_limit_khz

  // Counter step that stops at zero
  function automatic logic [W-1:0] count_down(input logic [W-1:0] value);
    count_down = (value == '0) ? '0 : W'(value - ONE);
  endfunction : count_down

  // ---------------------------------------------------------------
  // Supervisor state
  // ---------------------------------------------------------------
  supervisor_pkg::supervisor_ctrl_type [1:0] ctrl_q;
  supervisor_pkg::supervisor_ctrl_type [1:0] ctrl_d;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [1:0] active_q;
  logic [1:0] active_d;
  logic [1:0] comp_on_q;
  logic [1:0] comp_on_d;
  logic [W-1:0] mask_q [2];
  logic [W-1:0] mask_d [2];
  logic por_q;
  logic por_d;
  logic tristate_q;
  logic tristate_d;
  logic deep_sleep;
  logic [1:0] accept;
  logic [1:0] settling;

  // Controls, comparator power, settling masks, flags and resets
  always_comb begin
    deep_sleep = (power_mode == supervisor_pkg::PM_SLEEP2) ||
                 (power_mode == supervisor_pkg::PM_SLEEP3) ||
                 (power_mode == supervisor_pkg::PM_SLEEP4);
    por_d = 1'b0;
    for (int i = 0; i < 2; i++) begin
      ctrl_d[i] = ctrl_q[i];
      active_d[i] = active_q[i];
      if (soft_power_up_clear) begin
        ctrl_d[i] = supervisor_pkg::CTRL_RESET;
        // A supervisor that was off leaves its flags dead
        active_d[i] = ctrl_q[i].supervisor_enable;
      end else if (supervisor_ctrl_write[i]) begin
        ctrl_d[i] = supervisor_ctrl_wdata;
        active_d[i] = 1'b1;
      end
      // Off in sleep 2-4 unless kept; software must keep fast ones on
      comp_on_d[i] = ctrl_d[i].supervisor_enable &
        ~(deep_sleep & ~ctrl_d[i].supervisor_sleep_keep);
      // A soft clear re-enables without starting the mask: the known
      // hazard is kept so software sees the same device
      if (comp_on_d[i] && !comp_on_q[i] && !soft_power_up_clear) begin
        mask_d[i] = ctrl_d[i].supervisor_fast_mode ?
          W'(supervisor_pkg::FAST_MASK_CYCLES - ONE) :
          W'(NORMAL_MASK_CYCLES - ONE);
      end else if (!comp_on_d[i]) begin
        mask_d[i] = '0;
      end else begin
        mask_d[i] = count_down(mask_q[i]);
      end
      settling[i] = comp_on_d[i] && (mask_d[i] != '0);
      // Output ignored while masked or while off
      accept[i] = supervisor_trip[i] & comp_on_q[i] & active_q[i] &
                  (mask_q[i] == '0);
      // Set wins over a clear in the same cycle
      flag_d[i] = (flag_q[i] & ~supervisor_event_clear[i]) |
                  accept[i];
      if (accept[i] && ctrl_q[i].supervisor_reset_enable) begin
        por_d = 1'b1;
      end
    end
    tristate_d = |(flag_d & settling);
  end

  // Power-on reset leaves both supervisors on and unmasked
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= {2{supervisor_pkg::CTRL_RESET}};
      flag_q <= 2'h0;
      active_q <= 2'h3;
      comp_on_q <= 2'h3;
      mask_q[0] <= '0;
      mask_q[1] <= '0;
      por_q <= 1'b0;
      tristate_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      active_q <= active_d;
      comp_on_q <= comp_on_d;
      mask_q[0] <= mask_d[0];
      mask_q[1] <= mask_d[1];
      por_q <= por_d;
      tristate_q <= tristate_d;
    end
  end

  // ---------------------------------------------------------------
  // Wake-up masking of CPU execution
  // ---------------------------------------------------------------
  supervisor_pkg::wake_state_type state_q;
  supervisor_pkg::wake_state_type state_d;
  supervisor_pkg::power_mode_type mode_q;
  logic [W-1:0] wake_cnt_q;
  logic [W-1:0] wake_cnt_d;
  logic [W-1:0] osc_cnt_q;
  logic [W-1:0] osc_cnt_d;
  logic hazard_q;
  logic hazard_d;
  logic wake_event;
  logic short_mask;
  logic over_limit;
  logic [15:0] eff_khz;

  // Mask length picked at the wake edge from the low-side settings
  always_comb begin
    wake_event = ((mode_q == supervisor_pkg::PM_SLEEP3) ||
                  (mode_q == supervisor_pkg::PM_SLEEP4)) &&
                 ((power_mode == supervisor_pkg::PM_ACTIVE) ||
                  (power_mode == supervisor_pkg::PM_SLEEP0) ||
                  (power_mode == supervisor_pkg::PM_SLEEP1));
    short_mask =
      (!ctrl_q[supervisor_pkg::LOW_SIDE].supervisor_enable &&
       !low_monitor_enable) ||
      (ctrl_q[supervisor_pkg::LOW_SIDE].supervisor_fast_mode &&
       low_monitor_fast);
    eff_khz = main_clock_khz >> main_clock_divider;
    over_limit = eff_khz > clock_limit_khz(core_level);
    state_d = state_q;
    wake_cnt_d = count_down(wake_cnt_q);
    osc_cnt_d = count_down(osc_cnt_q);
    hazard_d = hazard_q;
    case (state_q)
      supervisor_pkg::WAKE_IDLE: begin
        if (wake_event) begin
          state_d = supervisor_pkg::WAKE_MASK;
          wake_cnt_d = short_mask ?
            W'(supervisor_pkg::FAST_MASK_CYCLES - ONE) :
            W'(NORMAL_MASK_CYCLES - ONE);
          osc_cnt_d = W'(supervisor_pkg::OSC_OVERSHOOT_CYCLES - ONE);
          hazard_d = short_mask && over_limit;
        end
      end
      supervisor_pkg::WAKE_MASK: begin
        if (wake_cnt_q == '0) begin
          // Overshoot outlasting a short mask leaves the clock exposed
          state_d = (hazard_q && osc_cnt_q != '0) ?
            supervisor_pkg::WAKE_RISK :
            supervisor_pkg::WAKE_IDLE;
        end
      end
      supervisor_pkg::WAKE_RISK: begin
        if (osc_cnt_q == '0) begin
          state_d = supervisor_pkg::WAKE_IDLE;
        end
      end
      default: begin
        state_d = supervisor_pkg::WAKE_IDLE;
      end
    endcase
  end

  // Wake-up sequencer registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= supervisor_pkg::WAKE_IDLE;
      mode_q <= supervisor_pkg::PM_ACTIVE;
      wake_cnt_q <= '0;
      osc_cnt_q <= '0;
      hazard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= power_mode;
      wake_cnt_q <= wake_cnt_d;
      osc_cnt_q <= osc_cnt_d;
      hazard_q <= hazard_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign supervisor_ctrl = ctrl_q;
  assign supervisor_event_flag = flag_q;
  assign flag_function_active = active_q;
  assign comparator_on = comp_on_q;
  assign power_on_reset_request = por_q;
  assign pins_tristate = tristate_q;
  assign cpu_hold = (state_q == supervisor_pkg::WAKE_MASK);
  assign clock_overspeed_risk = (state_q == supervisor_pkg::WAKE_RISK);

endmodule : supply_supervisor_event_masking

// [tb/supply_comparator_model.sv]
// Supply comparator model standing behind the supervisor trip inputs
`timescale 1ns/10ps
module supply_comparator_model (
  input wire logic clk_sys,
  input wire logic [1:0] comparator_on,
  input wire logic [1:0] supply_low,
  output logic [1:0] supervisor_trip
);
  logic [1:0] noise_q = 2'h1;
  // An unpowered comparator gives junk, so its output toggles each cycle
  // Plain always: the declaration already gives the start value
  always @(posedge clk_sys) noise_q <= ~noise_q;
  // A powered comparator reports the commanded supply state at once
  assign supervisor_trip = (comparator_on & supply_low) |
    (~comparator_on & noise_q);
endmodule : supply_comparator_model

// [tb/supply_supervisor_event_masking_asserts.sv]
// Port-level checks for the supply supervisor block
`timescale 1ns/10ps
module supply_supervisor_event_masking_asserts (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_power_up_clear,
  input wire supervisor_pkg::power_mode_type power_mode,
  input wire logic [1:0] supervisor_ctrl_write,
  input wire supervisor_pkg::supervisor_ctrl_type supervisor_ctrl_wdata,
  input wire logic [1:0] supervisor_trip,
  input wire logic [1:0] supervisor_event_clear,
  input wire supervisor_pkg::supervisor_ctrl_type [1:0] supervisor_ctrl,
  input wire logic [1:0] supervisor_event_flag,
  input wire logic [1:0] flag_function_active,
  input wire logic [1:0] comparator_on,
  input wire logic power_on_reset_request,
  input wire logic pins_tristate,
  input wire logic cpu_hold
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Flag 0, resets and floating pins all trace back to their causes
  property p_sticky;
    supervisor_event_flag[0] && !supervisor_event_clear[0] |=>
      supervisor_event_flag[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_cause;
    $rose(supervisor_event_flag[0]) |-> $past(supervisor_trip[0]) &&
      $past(comparator_on[0]) && $past(flag_function_active[0]);
  endproperty
  a_cause: assert property (p_cause) else $error("flag uncaused");
  property p_por;
    power_on_reset_request |-> $past(supervisor_trip) != 2'h0;
  endproperty
  a_por: assert property (p_por) else $error("reset uncaused");
  property p_float;
    pins_tristate |-> $past(supervisor_event_flag) != 2'h0;
  endproperty
  a_float: assert property (p_float) else $error("pins float");
  // A write in the same cycle may restore the keep bit, so it is excluded
  property p_sleep_off;
    power_mode > supervisor_pkg::PM_SLEEP1 && !supervisor_ctrl_write[0] &&
      !supervisor_ctrl[0].supervisor_sleep_keep |=> !comparator_on[0];
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("cmp on");
  property p_wake;
    $past(power_mode) == supervisor_pkg::PM_SLEEP3 &&
      power_mode == supervisor_pkg::PM_ACTIVE |=> cpu_hold [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("no hold");
  property p_write;
    supervisor_ctrl_write[0] && !soft_power_up_clear |=>
      supervisor_ctrl[0] == $past(supervisor_ctrl_wdata) &&
      flag_function_active[0];
  endproperty
  a_write: assert property (p_write) else $error("write lost");
  property p_soft;
    soft_power_up_clear |=> supervisor_ctrl[0] == supervisor_pkg::CTRL_RESET
      && flag_function_active[0] == $past(supervisor_ctrl[0].supervisor_enable);
  endproperty
  a_soft: assert property (p_soft) else $error("soft clear");
endmodule : supply_supervisor_event_masking_asserts

// [tb/tb_supply_supervisor_event_masking.sv]
// Self-checking bench for the supply supervisor event masking block
`timescale 1ns/10ps
module tb_supply_supervisor_event_masking;
  localparam logic [15:0] NM = 16'h0028; // Short normal mask keeps runs brief
  localparam logic [15:0] FM = supervisor_pkg::FAST_MASK_CYCLES;
  // Overshoot outlasts the short mask by this many cycles
  localparam logic [15:0] RK = supervisor_pkg::CLOCK_RISK_CYCLES;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic sclr = 1'b0;
  supervisor_pkg::power_mode_type pm = supervisor_pkg::PM_ACTIVE;
  supervisor_pkg::supervisor_ctrl_type wd = 4'h0;
  supervisor_pkg::supervisor_ctrl_type [1:0] ctrl;
  logic [1:0] wr = 2'h0, clr = 2'h0, low = 2'h0, core = 2'h0;
  logic lme = 1'b1, lmf = 1'b0;
  logic [15:0] khz = 16'h0000;
  logic [2:0] div = 3'h0;
  logic [1:0] trip, flag, act, con;
  logic por, tri_s, hold, risk;
  int miscompares = 0;
  int total_checks = 0;
  // System clock
  always #2.5 clk_sys = ~clk_sys;
  supply_supervisor_event_masking #(.NORMAL_MASK_CYCLES(NM)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_power_up_clear(sclr),
    .power_mode(pm), .supervisor_ctrl_write(wr),
    .supervisor_ctrl_wdata(wd), .supervisor_trip(trip),
    .supervisor_event_clear(clr), .low_monitor_enable(lme),
    .low_monitor_fast(lmf), .core_level(core), .main_clock_khz(khz),
    .main_clock_divider(div), .supervisor_ctrl(ctrl),
    .supervisor_event_flag(flag), .flag_function_active(act),
    .comparator_on(con), .power_on_reset_request(por),
    .pins_tristate(tri_s), .cpu_hold(hold), .clock_overspeed_risk(risk));
  supply_comparator_model far_side (.clk_sys(clk_sys),
    .comparator_on(con), .supply_low(low), .supervisor_trip(trip));
  // Shared compare, wait, write and flag-clear steps
  task automatic chk(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk
  // Ends 1 ns past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr_ctrl(input int i, input logic [3:0] v);
    @(posedge clk_sys);
    wr[i] <= 1'b1;
    wd <= v;
    @(posedge clk_sys);
    wr <= 2'h0;
    #1;
  endtask : wr_ctrl
  task automatic pulse_clear(input logic [1:0] l);
    @(posedge clk_sys);
    low <= l;
    clr <= 2'h3;
    @(posedge clk_sys);
    clr <= 2'h0;
    #1;
  endtask : pulse_clear
  // Sleep, wake and count the hold; the window also spans the risk time
  task automatic wake(input logic [5:0] cfg, input logic [15:0] k,
    input logic [2:0] d, input logic [15:0] len, input logic r);
    int n;
    int nr;
    logic rs;
    n = 0;
    nr = 0;
    rs = 1'b0;
    wr_ctrl(1, {cfg[5:4], 2'h3});
    @(posedge clk_sys);
    {lme, lmf, core} <= cfg[3:0];
    khz <= k;
    div <= d;
    pm <= supervisor_pkg::PM_SLEEP3;
    repeat (4) @(posedge clk_sys);
    pm <= supervisor_pkg::PM_ACTIVE;
    repeat (2000) begin
      cyc(1);
      n += (hold === 1'b1);
      rs |= risk;
      nr += (risk === 1'b1);
    end
    chk(16'(n), len, "hold length");
    chk(rs, r, "overspeed flag");
    chk(16'(nr), r ? RK : 16'h0000, "overspeed length");
  endtask : wake
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(1);
    chk(ctrl, {2{supervisor_pkg::CTRL_RESET}}, "reset ctrl");
    chk({act, con, flag, hold}, 7'h78, "reset state");
    $display("t1 reset done");
    @(posedge clk_sys);
    low <= 2'h1;
    cyc(1);
    chk({flag, por}, 3'h3, "unmasked event");
    @(posedge clk_sys);
    low <= 2'h0;
    cyc(8);
    chk(flag, 2'h1, "sticky flag");
    $display("t2 unmasked start done");
    wr_ctrl(0, 4'h0);
    @(posedge clk_sys);
    low <= 2'h1;
    // Fast and kept on in sleep, but an event must not request a reset
    wr_ctrl(0, 4'hE);
    cyc(2);
    chk(tri_s, 1'b1, "pins float");
    pulse_clear(2'h1);
    // Enable edge lies 4 cycles back; the 400-cycle mask ends exactly here
    cyc(395);
    chk(flag, 2'h0, "fast mask");
    cyc(1);
    chk({flag, tri_s, por}, 4'h4, "event after mask");
    pulse_clear(2'h0);
    $display("t3 fast mask done");
    wr_ctrl(0, 4'h0);
    @(posedge clk_sys);
    sclr <= 1'b1;
    low <= 2'h1;
    @(posedge clk_sys);
    sclr <= 1'b0;
    cyc(0);
    chk({act, ctrl[0]}, {2'h2, supervisor_pkg::CTRL_RESET},
      "soft clear");
    cyc(60);
    chk(flag, 2'h0, "dead flags");
    wr_ctrl(0, 4'h9);
    chk(act, 2'h3, "flags revived");
    cyc(52);
    chk(flag, 2'h1, "revived event");
    pulse_clear(2'h0);
    $display("t4 soft clear done");
    // Each power mode is requested in turn, ending in sleep 4
    for (int m = 0; m < 6; m++) begin
      @(posedge clk_sys);
      pm <= supervisor_pkg::power_mode_type'(m);
      cyc(2);
      chk(con, (m > 2) ? 2'h0 : 2'h3, "sleep comparators");
    end
    wr_ctrl(0, 4'hB);
    cyc(2);
    chk(con, 2'h1, "keep bit");
    @(posedge clk_sys);
    pm <= supervisor_pkg::PM_ACTIVE;
    cyc(2);
    chk(hold, 1'b1, "wake from sleep 4");
    cyc(98);
    $display("t5 sleep done");
    wake(6'h28, 16'h4E20, 3'h0, NM, 1'b0);
    wake(6'h00, 16'h4E20, 3'h0, FM, 1'b1);
    wake(6'h3C, 16'h1F40, 3'h1, FM, 1'b0);
    wake(6'h3D, 16'h1B59, 3'h0, FM, 1'b1);
    wake(6'h3E, 16'h2AF8, 3'h0, FM, 1'b0);
    wake(6'h3F, 16'h36B1, 3'h0, FM, 1'b1);
    wake(6'h30, 16'h4E20, 3'h0, NM, 1'b0);
    $display("t6 wake done");
    complete_run;
  end
  // Cuts a hang short well after the expected run of about 74 us
  initial begin
    #300000;
    miscompares++;
    complete_run;
  end
endmodule : tb_supply_supervisor_event_masking
bind supply_supervisor_event_masking supply_supervisor_event_masking_asserts
  chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .soft_power_up_clear(soft_power_up_clear), .power_mode(power_mode),
  .supervisor_ctrl_write(supervisor_ctrl_write),
  .supervisor_ctrl_wdata(supervisor_ctrl_wdata),
  .supervisor_trip(supervisor_trip),
  .supervisor_event_clear(supervisor_event_clear),
  .supervisor_ctrl(supervisor_ctrl),
  .supervisor_event_flag(supervisor_event_flag),
  .flag_function_active(flag_function_active),
  .comparator_on(comparator_on),
  .power_on_reset_request(power_on_reset_request),
  .pins_tristate(pins_tristate), .cpu_hold(cpu_hold));
